// *** design/fodc_pkg.sv ***
// Package: constants and types of the fractional divider config bank
//----------------------------------------------------------------------
// Behaviour
// - Group at 0x110; config 0x0, phase 0x8
// - Bit 63 one powers divider down
// - Bit 62 one disables the divider
// - Bit 61 is divider reset, default off
// - Bit 60 holds accumulator in reset
// - Bits 59:26 fraction over two^34
// - Integer and fraction staged, applied on top byte
// - Bits 25:9 half ratio, divide by twice
// - Zero bypasses second stage; one is illegal
// - Bits 8:0 first integer, default 0x64
//----------------------------------------------------------------------
package fodc_pkg;

   //----------------------------------------------------------------
   // Address map (byte addresses, 8-bit data)
   //----------------------------------------------------------------
   localparam int ADDR_W = 12;
   localparam int DATA_W = 8;
   localparam logic [11:0] GROUP_BASE = 12'h110;
   localparam logic [11:0] CFG_OFS = 12'h000;
   localparam logic [11:0] PHASE_OFS = 12'h008;
   localparam logic [11:0] APPLIED_OFS = 12'h010;
   localparam logic [11:0] STATUS_OFS = 12'h018;
   localparam logic [11:0] CFG_BYTES = 12'h008;
   localparam logic [11:0] PHASE_BYTES = 12'h002;
   localparam logic [11:0] APPLIED_BYTES = 12'h008;
   localparam logic [11:0] STATUS_BYTES = 12'h001;

   //----------------------------------------------------------------
   // Config register fields
   //----------------------------------------------------------------
   localparam int CFG_W = 64;
   localparam int PD_BIT = 63;
   localparam int DIS_BIT = 62;
   localparam int RST_BIT = 61;
   localparam int ACC_BIT = 60;
   localparam int FRAC_LSB = 26;
   localparam int FRAC_W = 34;
   localparam int HALF_LSB = 9;
   localparam int HALF_W = 17;
   localparam int INT_LSB = 0;
   localparam int INT_W = 9;
   localparam logic [2:0] INT_TOP_BYTE = 3'h1;
   localparam logic [2:0] FRAC_TOP_BYTE = 3'h7;
   localparam logic [8:0] INT_RESET = 9'h064;
   localparam logic [33:0] FRAC_RESET = 34'h0_0000_0000;
   localparam logic [16:0] HALF_RESET = 17'h0_0000;
   localparam logic [16:0] HALF_BYPASS = 17'h0_0000;
   localparam logic [16:0] HALF_ILLEGAL = 17'h0_0001;

   //----------------------------------------------------------------
   // Phase register layout (fields decoded elsewhere)
   //----------------------------------------------------------------
   localparam int PHASE_W = 16;
   localparam logic [15:0] PHASE_RESET = 16'h43F0;
   localparam logic [15:0] PHASE_MASK = 16'hE3FF;

   //----------------------------------------------------------------
   // Status byte and ratio widths
   //----------------------------------------------------------------
   localparam int ST_PENDING = 0;
   localparam int ST_INVALID = 1;
   localparam int ST_BYPASS = 2;
   localparam int RATIO1_W = INT_W + FRAC_W;
   localparam int RATIO2_W = HALF_W + 1;
   localparam int TOTAL_W = RATIO1_W + RATIO2_W;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } fodc_bus_req_t;

   typedef struct packed {
      logic divider_power_down;
      logic divider_disable;
      logic divider_reset;
      logic acc_reset;
   } fodc_ctrl_t;

   typedef struct packed {
      logic [INT_W-1:0] first_stage_integer;
      logic [FRAC_W-1:0] first_stage_fraction;
      logic [HALF_W-1:0] second_stage_half_ratio;
   } fodc_ratio_t;

endpackage

// *** design/fodc_ratio.sv ***
// Module: effective division ratio of the two divider stages
`timescale 1ns/100ps
module fodc_ratio (
   input wire logic clk,
   input wire logic rst_n,
   input wire fodc_pkg::fodc_ratio_t ratio,
   output logic [fodc_pkg::RATIO1_W-1:0] first_stage_ratio,
   output logic [fodc_pkg::RATIO2_W-1:0] second_stage_ratio,
   output logic [fodc_pkg::TOTAL_W-1:0] total_division
);
   import fodc_pkg::*;

   logic [RATIO1_W-1:0] r1_ff, nxt_r1;
   logic [RATIO2_W-1:0] r2_ff, nxt_r2;
   logic [TOTAL_W-1:0] tot_ff, nxt_tot;

   //----------------------------------------------------------------
   // Ratio arithmetic, fixed point with 34 fraction bits
   //----------------------------------------------------------------
   always_comb begin
      // Fraction is a numerator over two^34, so it is the low bits
      nxt_r1 = {ratio.first_stage_integer,
                ratio.first_stage_fraction};
      nxt_r2 = {ratio.second_stage_half_ratio, 1'b0};
      if (ratio.second_stage_half_ratio == HALF_BYPASS) begin
         nxt_tot = {{RATIO2_W{1'b0}}, nxt_r1};
      end else begin
         nxt_tot = TOTAL_W'(nxt_r1) * TOTAL_W'(nxt_r2);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         // Match the default ratio, so release shows no false step
         r1_ff <= {INT_RESET, FRAC_RESET};
         r2_ff <= {HALF_RESET, 1'b0};
         tot_ff <= TOTAL_W'({INT_RESET, FRAC_RESET});
      end else begin
         r1_ff <= nxt_r1;
         r2_ff <= nxt_r2;
         tot_ff <= nxt_tot;
      end
   end

   assign first_stage_ratio = r1_ff;
   assign second_stage_ratio = r2_ff;
   assign total_division = tot_ff;

endmodule

// *** design/fodc_regs.sv ***
// Module: register bank of the two-stage fractional output divider
//
// Strobed register access was decided locally.
`timescale 1ns/100ps
module fodc_regs (
   input wire logic clk,
   input wire logic rst_n,
   input wire fodc_pkg::fodc_bus_req_t bus,
   output logic [fodc_pkg::DATA_W-1:0] rdata,
   output fodc_pkg::fodc_ctrl_t ctrl,
   output fodc_pkg::fodc_ratio_t ratio,
   output logic ratio_commit,
   output logic second_stage_bypass,
   output logic second_stage_invalid,
   output logic [fodc_pkg::RATIO1_W-1:0] first_stage_ratio,
   output logic [fodc_pkg::RATIO2_W-1:0] second_stage_ratio,
   output logic [fodc_pkg::TOTAL_W-1:0] total_division,
   output logic [fodc_pkg::PHASE_W-1:0] phase_cfg
);
   import fodc_pkg::*;

   //----------------------------------------------------------------
   // Address decoding helper
   //----------------------------------------------------------------
   // Returns {hit, byte index} for a window of bytes at the group base
   function automatic logic [3:0] byte_hit(
      input logic [ADDR_W-1:0] addr,
      input logic [ADDR_W-1:0] ofs,
      input logic [ADDR_W-1:0] len
   );
      logic [ADDR_W-1:0] start;
      logic [ADDR_W-1:0] rel;
      start = GROUP_BASE + ofs;
      rel = addr - start;
      byte_hit = {(addr >= start) && (rel < len), rel[2:0]};
   endfunction

   // Selects one byte of a 64-bit image
   function automatic logic [DATA_W-1:0] pick_byte(
      input logic [CFG_W-1:0] img,
      input logic [2:0] idx
   );
      pick_byte = img[{idx, 3'h0} +: DATA_W];
   endfunction

   //----------------------------------------------------------------
   // State
   //----------------------------------------------------------------
   logic [CFG_W-1:0] cfg_ff, nxt_cfg;
   logic [INT_W-1:0] int_ff, nxt_int;
   logic [FRAC_W-1:0] frac_ff, nxt_frac;
   logic commit_ff, nxt_commit;
   logic [PHASE_W-1:0] phase_ff, nxt_phase;
   logic [DATA_W-1:0] rdata_ff, nxt_rdata;

   logic [3:0] cfg_sel;
   logic [3:0] phase_sel;
   logic [3:0] appl_sel;
   logic [3:0] stat_sel;
   logic cfg_wr;
   logic top_byte_wr;
   logic [CFG_W-1:0] applied_img;
   logic [DATA_W-1:0] status_byte;
   logic [HALF_W-1:0] half_now;
   logic pending;

   //----------------------------------------------------------------
   // Decode
   //----------------------------------------------------------------
   always_comb begin
      cfg_sel = byte_hit(bus.addr, CFG_OFS, CFG_BYTES);
      phase_sel = byte_hit(bus.addr, PHASE_OFS, PHASE_BYTES);
      appl_sel = byte_hit(bus.addr, APPLIED_OFS, APPLIED_BYTES);
      stat_sel = byte_hit(bus.addr, STATUS_OFS, STATUS_BYTES);
      cfg_wr = bus.wr && cfg_sel[3];
      // Either field's top byte commits the whole group
      top_byte_wr = cfg_wr && ((cfg_sel[2:0] == INT_TOP_BYTE) ||
                    (cfg_sel[2:0] == FRAC_TOP_BYTE));
   end

   //----------------------------------------------------------------
   // Config image: control bits and second stage act at once
   //----------------------------------------------------------------
   always_comb begin
      nxt_cfg = cfg_ff;
      if (cfg_wr) begin
         nxt_cfg[{cfg_sel[2:0], 3'h0} +: DATA_W] = bus.wdata;
      end
   end

   //----------------------------------------------------------------
   // Atomic group: integer and fraction staged in the image
   //----------------------------------------------------------------
   always_comb begin
      nxt_int = int_ff;
      nxt_frac = frac_ff;
      nxt_commit = 1'b0;
      // Lower bytes only stage, so a half-written ratio never
      // reaches the stage and glitches the output frequency
      if (top_byte_wr) begin
         nxt_int = nxt_cfg[INT_LSB +: INT_W];
         nxt_frac = nxt_cfg[FRAC_LSB +: FRAC_W];
         nxt_commit = 1'b1;
      end
   end

   //----------------------------------------------------------------
   // Phase register: stored here, decoded by the phase logic
   //----------------------------------------------------------------
   always_comb begin
      nxt_phase = phase_ff;
      if (bus.wr && phase_sel[3]) begin
         nxt_phase[{phase_sel[0], 3'h0} +: DATA_W] = bus.wdata;
      end
      // Reserved bits never hold a one
      nxt_phase = nxt_phase & PHASE_MASK;
   end

   //----------------------------------------------------------------
   // Read path, data valid in the cycle after the strobe only
   //----------------------------------------------------------------
   always_comb begin
      nxt_rdata = '0;
      if (bus.rd) begin
         if (cfg_sel[3]) begin
            nxt_rdata = pick_byte(cfg_ff, cfg_sel[2:0]);
         end else if (phase_sel[3]) begin
            nxt_rdata = phase_ff[{phase_sel[0], 3'h0} +: DATA_W];
         end else if (appl_sel[3]) begin
            nxt_rdata = pick_byte(applied_img, appl_sel[2:0]);
         end else if (stat_sel[3]) begin
            nxt_rdata = status_byte;
         end else begin
            // Unmapped addresses read as zero
            nxt_rdata = '0;
         end
      end
   end

   //----------------------------------------------------------------
   // Registers
   //----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         // Power-up, enable, resets deasserted, integer 0x64
         cfg_ff <= {1'b0, 1'b0, 1'b0, 1'b0, FRAC_RESET, HALF_RESET,
                    INT_RESET};
         int_ff <= INT_RESET;
         frac_ff <= FRAC_RESET;
         commit_ff <= 1'b0;
         phase_ff <= PHASE_RESET;
         rdata_ff <= '0;
      end else begin
         cfg_ff <= nxt_cfg;
         int_ff <= nxt_int;
         frac_ff <= nxt_frac;
         commit_ff <= nxt_commit;
         phase_ff <= nxt_phase;
         rdata_ff <= nxt_rdata;
      end
   end

   //----------------------------------------------------------------
   // Applied view and status
   //----------------------------------------------------------------
   always_comb begin
      half_now = cfg_ff[HALF_LSB +: HALF_W];
      applied_img = cfg_ff;
      applied_img[INT_LSB +: INT_W] = int_ff;
      applied_img[FRAC_LSB +: FRAC_W] = frac_ff;
      // Staged group differs from what the divider uses
      pending = (cfg_ff[INT_LSB +: INT_W] != int_ff) ||
                (cfg_ff[FRAC_LSB +: FRAC_W] != frac_ff);
      status_byte = '0;
      status_byte[ST_PENDING] = pending;
      status_byte[ST_INVALID] = (half_now == HALF_ILLEGAL);
      status_byte[ST_BYPASS] = (half_now == HALF_BYPASS);
   end

   //----------------------------------------------------------------
   // Outputs to the divider
   //----------------------------------------------------------------
   // Reset sequencing is left to software; no interlock is forced
   assign ctrl.divider_power_down = cfg_ff[PD_BIT];
   assign ctrl.divider_disable = cfg_ff[DIS_BIT];
   assign ctrl.divider_reset = cfg_ff[RST_BIT];
   assign ctrl.acc_reset = cfg_ff[ACC_BIT];
   assign ratio.first_stage_integer = int_ff;
   assign ratio.first_stage_fraction = frac_ff;
   assign ratio.second_stage_half_ratio = half_now;
   assign ratio_commit = commit_ff;
   assign second_stage_bypass = status_byte[ST_BYPASS];
   assign second_stage_invalid = status_byte[ST_INVALID];
   assign phase_cfg = phase_ff;
   assign rdata = rdata_ff;

   //----------------------------------------------------------------
   // Ratio arithmetic
   //----------------------------------------------------------------
   fodc_ratio u_ratio (
      .clk(clk),
      .rst_n(rst_n),
      .ratio(ratio),
      .first_stage_ratio(first_stage_ratio),
      .second_stage_ratio(second_stage_ratio),
      .total_division(total_division)
   );

endmodule

// *** test/fodc_regs_asserts.sv ***
// Checker: concurrent assertions on the config bank ports
`timescale 1ns/100ps
module fodc_regs_asserts (
   input wire logic clk,
   input wire logic rst_n,
   input wire fodc_pkg::fodc_bus_req_t bus,
   input wire logic [fodc_pkg::DATA_W-1:0] rdata,
   input wire fodc_pkg::fodc_ctrl_t ctrl,
   input wire fodc_pkg::fodc_ratio_t ratio,
   input wire logic ratio_commit,
   input wire logic second_stage_bypass,
   input wire logic second_stage_invalid,
   input wire logic [fodc_pkg::RATIO1_W-1:0] first_stage_ratio,
   input wire logic [fodc_pkg::RATIO2_W-1:0] second_stage_ratio,
   input wire logic [fodc_pkg::TOTAL_W-1:0] total_division,
   input wire logic [fodc_pkg::PHASE_W-1:0] phase_cfg
);
   import fodc_pkg::*;
   // ------------------------------
   // Decode of the committing writes
   // ------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic top_wr;
   logic commit_wr;
   assign top_wr = bus.wr && bus.addr == GROUP_BASE + 12'h007;
   assign commit_wr = top_wr || (bus.wr && bus.addr == GROUP_BASE + 12'h001);
   sequence s_lone_commit;
      commit_wr ##1 !commit_wr;
   endsequence
   sequence s_pulse;
      ratio_commit ##1 !ratio_commit;
   endsequence
   // ------------------------------
   // Properties
   // ------------------------------
   a_commit_pulse: assert property (s_lone_commit |-> s_pulse)
      else $error("commit pulse missing after top byte write");
   a_no_commit: assert property (!commit_wr |=> !ratio_commit)
      else $error("commit pulse without top byte write");
   a_ratio_hold: assert property (!ratio_commit |->
      $stable({ratio.first_stage_integer, ratio.first_stage_fraction}))
      else $error("applied ratio moved without commit");
   a_power_down: assert property (top_wr |=>
      ctrl.divider_power_down == $past(bus.wdata[7]))
      else $error("power down bit wrong");
   a_disable_bit: assert property (top_wr |=>
      ctrl.divider_disable == $past(bus.wdata[6]))
      else $error("disable bit wrong");
   a_divider_reset: assert property (top_wr |=>
      ctrl.divider_reset == $past(bus.wdata[5]))
      else $error("divider reset bit wrong");
   a_acc_reset: assert property (top_wr |=>
      ctrl.acc_reset == $past(bus.wdata[4]))
      else $error("accumulator reset bit wrong");
   a_ctrl_hold: assert property (!top_wr |=> $stable(ctrl))
      else $error("control bits moved without write");
   a_second_ratio: assert property (second_stage_ratio ==
      {$past(ratio.second_stage_half_ratio), 1'b0})
      else $error("second stage ratio not twice the setting");
   a_bypass_flags: assert property (
      second_stage_bypass == (ratio.second_stage_half_ratio == HALF_BYPASS)
      && second_stage_invalid ==
      (ratio.second_stage_half_ratio == HALF_ILLEGAL))
      else $error("bypass or invalid flag wrong");
   a_first_ratio: assert property (first_stage_ratio ==
      $past({ratio.first_stage_integer, ratio.first_stage_fraction}))
      else $error("first stage ratio wrong");
   a_total_div: assert property (total_division ==
      (second_stage_ratio == 0 ? TOTAL_W'(first_stage_ratio) :
      TOTAL_W'(first_stage_ratio) * TOTAL_W'(second_stage_ratio)))
      else $error("total division wrong");
   a_rdata_idle: assert property (!$past(bus.rd) |-> rdata == 8'h00)
      else $error("read data outside read answer");
endmodule

bind fodc_regs fodc_regs_asserts u_asserts (.clk, .rst_n, .bus, .rdata,
   .ctrl, .ratio, .ratio_commit, .second_stage_bypass, .second_stage_invalid,
   .first_stage_ratio, .second_stage_ratio, .total_division, .phase_cfg);

// *** test/frac_output_divider_config_bench.sv ***
// Testbench: self-checking run of the fractional divider config bank
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
   n_mismatch++; $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module frac_output_divider_config_bench;
   import fodc_pkg::*;
   logic clk, rst_n, ratio_commit, bypass, invalid;
   fodc_bus_req_t bus;
   logic [DATA_W-1:0] rdata;
   fodc_ctrl_t ctrl;
   fodc_ratio_t ratio;
   logic [RATIO1_W-1:0] r1;
   logic [RATIO2_W-1:0] r2;
   logic [TOTAL_W-1:0] tot;
   logic [PHASE_W-1:0] phase_cfg;
   // Model: staged image, applied int/frac, phase
   logic [63:0] img;
   logic [42:0] app;
   logic [15:0] ph;
   logic [7:0] seq [6] = '{8'hE0, 8'h20, 8'h60, 8'h20, 8'h10, 8'h00};
   logic [7:0] hv [4] = '{8'h02, 8'h04, 8'h00, 8'hFE};
   logic [11:0] a;
   int n_mismatch, n_tests;
   fodc_regs u_dut (.clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
      .ctrl(ctrl), .ratio(ratio), .ratio_commit(ratio_commit),
      .second_stage_bypass(bypass), .second_stage_invalid(invalid),
      .first_stage_ratio(r1), .second_stage_ratio(r2),
      .total_division(tot), .phase_cfg(phase_cfg));
   // ------------------------------
   // Model and checks
   // ------------------------------
   function automatic logic [7:0] exp_rd(input logic [11:0] ad);
      logic [63:0] v;
      logic [11:0] o;
      o = ad - GROUP_BASE;
      v = 64'h0;
      if (ad < GROUP_BASE) return 8'h00;
      if (o < 8) v = img;
      else if (o < 10) v = {48'h0, ph};
      else if (o >= 16 && o < 24) v = {img[63:60], app[33:0], img[25:9],
         app[42:34]};
      else if (o == 24) v = {61'h0, img[25:9] == 0, img[25:9] == 1,
         {img[8:0], img[59:26]} != app};
      return v[8*o[2:0] +: 8];
   endfunction
   task automatic check_now();
      `CHK("ctrl", img[63:60], ctrl)
      `CHK("ratio", {app, img[25:9]}, ratio)
      `CHK("bypass", img[25:9] == 0, bypass)
      `CHK("invalid", img[25:9] == 1, invalid)
      `CHK("phase", ph, phase_cfg)
   endtask
   task automatic check_late();
      logic [TOTAL_W-1:0] t;
      t = TOTAL_W'(app) * TOTAL_W'({img[25:9], 1'b0});
      if (img[25:9] == 0) t = TOTAL_W'(app);
      `CHK("first ratio", app, r1)
      `CHK("second ratio", {img[25:9], 1'b0}, r2)
      `CHK("total", t, tot)
   endtask
   // ------------------------------
   // Bus tasks
   // ------------------------------
   task automatic wr(input logic [11:0] ad, input logic [7:0] d);
      logic [11:0] o;
      logic c;
      o = ad - GROUP_BASE;
      c = 1'b0;
      @(posedge clk);
      bus.addr <= ad;
      bus.wdata <= d;
      bus.wr <= 1'b1;
      @(posedge clk);
      bus.wr <= 1'b0;
      if (ad >= GROUP_BASE && o < 8) begin
         img[8*o[2:0] +: 8] = d;
         if (o[2:0] == INT_TOP_BYTE || o[2:0] == FRAC_TOP_BYTE) begin
            app = {img[8:0], img[59:26]};
            c = 1'b1;
         end
      end else if (ad >= GROUP_BASE && o >= 8 && o < 10) begin
         ph[8*o[0] +: 8] = d & PHASE_MASK[8*o[0] +: 8];
      end
      #1;
      check_now();
      `CHK("commit", c, ratio_commit)
      @(posedge clk);
      #1;
      check_late();
      `CHK("commit end", 1'b0, ratio_commit)
   endtask
   task automatic rd(input logic [11:0] ad);
      logic [7:0] e;
      e = exp_rd(ad);
      @(posedge clk);
      bus.addr <= ad;
      bus.rd <= 1'b1;
      @(posedge clk);
      bus.rd <= 1'b0;
      #1;
      `CHK("rdata", e, rdata)
   endtask
   task automatic do_reset();
      @(posedge clk);
      rst_n <= 1'b0;
      img = {55'h0, INT_RESET};
      app = {INT_RESET, FRAC_RESET};
      ph = PHASE_RESET;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      #1;
      check_now();
      check_late();
      for (int i = 0; i < 10; i++) rd(GROUP_BASE + 12'(i));
   endtask
   task automatic stop_test();
      $display("mismatches %0d, checks %0d", n_mismatch, n_tests);
      if (n_mismatch == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // ------------------------------
   // Sequence
   // ------------------------------
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial begin
      // Far beyond the run length, well inside the cycle budget
      #400000;
      n_mismatch++;
      stop_test();
   end
   initial begin
      bus = '0;
      rst_n = 1'b0;
      n_mismatch = 0;
      n_tests = 0;
      void'($urandom(32'hA16B));
      do_reset();
      // Fraction bytes stay staged until the top byte
      for (int i = 3; i < 7; i++) wr(GROUP_BASE + 12'(i), 8'hA5);
      rd(GROUP_BASE + STATUS_OFS);
      wr(GROUP_BASE + 12'h007, 8'h0F);
      wr(GROUP_BASE, 8'h3C);
      wr(GROUP_BASE + 12'h001, 8'h01);
      // Low fraction bits cleared, as modulation would need
      wr(GROUP_BASE + 12'h003, 8'h00);
      foreach (seq[i]) wr(GROUP_BASE + 12'h007, seq[i]);
      foreach (hv[i]) wr(GROUP_BASE + 12'h001, hv[i]);
      wr(GROUP_BASE + 12'h002, 8'hFF);
      rd(GROUP_BASE + STATUS_OFS);
      // Random traffic, unmapped and read-only places included
      repeat (80) begin
         a = 12'h108 + 12'($urandom_range(0, 39));
         if ($urandom_range(0, 1) == 1) wr(a, 8'($urandom));
         else rd(a);
      end
      // Reset in mid-run returns the defaults
      wr(GROUP_BASE + 12'h007, 8'hFF);
      do_reset();
      stop_test();
   end
endmodule
